// [src/rsp_buf2.sv]
/*
  Two-entry skid buffer carrying interpolation points to the filter datapath.
  Assumes both sides are on the same clock; ready may be combinational.
*/
`timescale 1ns/10ps
`default_nettype none
module rsp_buf2 #(
  parameter int WIDTH = 8
) (
  input wire logic clock, // System clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic in_valid, // Source offers a word
  output logic in_ready, // Buffer can take a word
  input wire logic [WIDTH-1:0] in_data, // Word from source
  output logic out_valid, // Word available
  input wire logic out_ready, // Sink takes the word
  output logic [WIDTH-1:0] out_data // Oldest word
);

  logic [WIDTH-1:0] slot0;
  logic [WIDTH-1:0] slot1;
  logic [1:0] count;
  logic [WIDTH-1:0] next_slot0;
  logic [WIDTH-1:0] next_slot1;
  logic [1:0] next_count;
  logic push;
  logic pop;

  assign in_ready = (count != 2'd2);
  assign out_valid = (count != 2'd0);
  assign out_data = slot0;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_slot0 = slot0;
    next_slot1 = slot1;
    next_count = count;
    if (pop) begin
      next_slot0 = slot1;
    end
    if (push) begin
      if (count == 2'd0 || (count == 2'd1 && pop)) begin
        next_slot0 = in_data;
      end else if (pop) begin
        next_slot1 = in_data;
      end else begin
        next_slot1 = in_data;
      end
    end
    if (push && !pop) begin
      next_count = count + 2'd1;
    end else if (pop && !push) begin
      next_count = count - 2'd1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      slot0 <= '0;
      slot1 <= '0;
      count <= 2'd0;
    end else begin
      slot0 <= next_slot0;
      slot1 <= next_slot1;
      count <= next_count;
    end
  end

  chk_buf_noover : assert property (@(posedge clock) disable iff (rst) count != 2'd3)
    else $error("buffer count overflow");

endmodule : rsp_buf2
`default_nettype wire

// [src/rsp_ctrl.sv]
/*
  Resize start-phase control: holds start phases, steps, edge flags, method
  selectors and partial-area size behind an AXI4-Lite slave, and walks a
  phase accumulator that emits one interpolation point per output pixel.
  Assumes software keeps its own programming constraints; one clock domain.
*/
// How it works
// - Horizontal phase: 10-bit integer, 12-bit fraction.
// - Vertical phase: 9-bit integer, 12-bit fraction.
// - Start phase sets the two-pixel mixing weights.
// - Fraction spans one pixel; 800 hex halves.
// - First point at start phase, offset carried.
// - No partial resize while gradation is selected.
// - Vertical step: 2-bit integer, 12-bit fraction.
// - Resize off acts as unity step, fields kept.
// - Four selectors: bilinear zero, nearest one.
`timescale 1ns/10ps
`default_nettype none
module rsp_ctrl
  import rsp_pkg::*;
#(
  parameter int CNT_W = 12
) (
  input wire logic clock, // 125 MHz system clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic [RSP_ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [RSP_ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic line_start, // Pulse: begin a run of points
  input wire logic [CNT_W-1:0] point_count, // Points in the run
  input wire logic vert_axis, // Run uses vertical phase and step
  output logic run_busy, // Run in progress
  output logic point_valid, // Interpolation point available
  input wire logic point_ready, // Datapath takes the point
  output rsp_point_t point // Interpolation point
);

  initial begin
    if (CNT_W < 1 || CNT_W > 16) begin
      $error("rsp_ctrl: CNT_W out of range");
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [4:0] setup, next_setup;
  logic [3:0] method, next_method;
  rsp_hphase_t hphase, next_hphase;
  rsp_vphase_t vphase, next_vphase;
  rsp_step_t hstep, next_hstep;
  rsp_step_t vstep, next_vstep;
  logic [RSP_SIZE_W-1:0] src_set_width, next_src_set_width;
  logic [RSP_SIZE_W-1:0] src_set_height, next_src_set_height;
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [RSP_ADDR_W-1:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic bvalid, next_bvalid, rvalid, next_rvalid;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  logic [31:0] wr_word;
  logic wr_fire;
  logic partial_refused;

  assign s_axi_awready = !aw_held && !bvalid;
  assign s_axi_wready = !w_held && !bvalid;
  assign s_axi_arready = !rvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rresp = rresp;
  assign s_axi_rdata = rdata;
  assign wr_fire = aw_held && w_held && !bvalid;

  assign partial_refused = setup[RSP_SETUP_PART] && setup[RSP_SETUP_GRAD];

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  always_comb begin
    next_setup = setup;
    next_method = method;
    next_hphase = hphase;
    next_vphase = vphase;
    next_hstep = hstep;
    next_vstep = vstep;
    next_src_set_width = src_set_width;
    next_src_set_height = src_set_height;
    next_aw_held = aw_held || (s_axi_awvalid && s_axi_awready);
    next_w_held = w_held || (s_axi_wvalid && s_axi_wready);
    next_aw_addr = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : aw_addr;
    next_w_data = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : w_data;
    next_w_strb = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb : w_strb;
    next_bvalid = bvalid && !s_axi_bready;
    next_bresp = bresp;
    next_rvalid = rvalid && !s_axi_rready;
    next_rresp = rresp;
    next_rdata = rdata;
    wr_word = '0;
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RSP_RESP_OKAY;
      case (aw_addr)
        RSP_OFF_SETUP: begin
          wr_word = merge({27'h0, setup}, w_data, w_strb);
          next_setup = wr_word[4:0];
        end
        RSP_OFF_METHOD: begin
          wr_word = merge({28'h0, method}, w_data, w_strb);
          next_method = wr_word[3:0];
        end
        RSP_OFF_HPHASE: begin
          wr_word = merge({6'h0, hphase.ipart, 4'h0, hphase.fpart}, w_data, w_strb);
          next_hphase = {wr_word[RSP_INT_LSB +: RSP_HINT_W], wr_word[RSP_FRAC_W-1:0]};
        end
        RSP_OFF_VPHASE: begin
          wr_word = merge({7'h0, vphase.ipart, 4'h0, vphase.fpart}, w_data, w_strb);
          next_vphase = {wr_word[RSP_INT_LSB +: RSP_VINT_W], wr_word[RSP_FRAC_W-1:0]};
        end
        RSP_OFF_HSTEP: begin
          wr_word = merge({14'h0, hstep.ipart, 4'h0, hstep.fpart}, w_data, w_strb);
          next_hstep = {wr_word[RSP_INT_LSB +: RSP_DINT_W], wr_word[RSP_FRAC_W-1:0]};
        end
        RSP_OFF_VSTEP: begin
          wr_word = merge({14'h0, vstep.ipart, 4'h0, vstep.fpart}, w_data, w_strb);
          next_vstep = {wr_word[RSP_INT_LSB +: RSP_DINT_W], wr_word[RSP_FRAC_W-1:0]};
        end
        RSP_OFF_AREA: begin
          wr_word = merge({4'h0, src_set_height, 4'h0, src_set_width}, w_data, w_strb);
          next_src_set_width = wr_word[RSP_SIZE_W-1:0];
          next_src_set_height = wr_word[RSP_AREA_H_LSB +: RSP_SIZE_W];
        end
        RSP_OFF_STATUS: begin
          next_bresp = RSP_RESP_OKAY;
        end
        default: begin
          next_bresp = RSP_RESP_SLVERR;
        end
      endcase
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = RSP_RESP_OKAY;
      case (s_axi_araddr)
        RSP_OFF_SETUP: next_rdata = {27'h0, setup};
        RSP_OFF_METHOD: next_rdata = {28'h0, method};
        RSP_OFF_HPHASE: next_rdata = {6'h0, hphase.ipart, 4'h0, hphase.fpart};
        RSP_OFF_VPHASE: next_rdata = {7'h0, vphase.ipart, 4'h0, vphase.fpart};
        RSP_OFF_HSTEP: next_rdata = {14'h0, hstep.ipart, 4'h0, hstep.fpart};
        RSP_OFF_VSTEP: next_rdata = {14'h0, vstep.ipart, 4'h0, vstep.fpart};
        RSP_OFF_AREA: next_rdata = {4'h0, src_set_height, 4'h0, src_set_width};
        RSP_OFF_STATUS: next_rdata = {30'h0, partial_refused, run_busy};
        default: begin
          next_rdata = '0;
          next_rresp = RSP_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      setup <= '0;
      method <= '0;
      hphase <= '0;
      vphase <= '0;
      hstep <= {RSP_UNITY_INT, RSP_UNITY_FRAC};
      vstep <= {RSP_UNITY_INT, RSP_UNITY_FRAC};
      src_set_width <= '0;
      src_set_height <= '0;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      bvalid <= 1'b0;
      bresp <= RSP_RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= RSP_RESP_OKAY;
      rdata <= '0;
    end else begin
      setup <= next_setup;
      method <= next_method;
      hphase <= next_hphase;
      vphase <= next_vphase;
      hstep <= next_hstep;
      vstep <= next_vstep;
      src_set_width <= next_src_set_width;
      src_set_height <= next_src_set_height;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Phase accumulator
  // ----------------------------------------------------------------
  localparam int ACC_W = RSP_HINT_W + RSP_FRAC_W;
  logic [ACC_W-1:0] acc, next_acc;
  logic [CNT_W-1:0] left, next_left;
  logic busy, next_busy;
  logic [ACC_W-1:0] start_phase, step_eff;
  rsp_point_t cand;
  logic cand_ready;

  assign run_busy = busy;

  always_comb begin
    // resize off acts as unity step
    if (!setup[RSP_SETUP_EN]) begin
      step_eff = ACC_W'({RSP_UNITY_INT, RSP_UNITY_FRAC});
    end else if (vert_axis) begin
      step_eff = ACC_W'(vstep);
    end else begin
      step_eff = ACC_W'(hstep);
    end
    start_phase = vert_axis ? ACC_W'(vphase) : ACC_W'(hphase);
    cand.src_index = acc[ACC_W-1 -: RSP_HINT_W];
    cand.weight_far = acc[RSP_FRAC_W-1:0];
    cand.weight_near = (RSP_FRAC_W+1)'(1 << RSP_FRAC_W) - {1'b0, acc[RSP_FRAC_W-1:0]};
    cand.nearest = vert_axis ? method[2] : method[0];
    cand.nearest_alpha = vert_axis ? method[3] : method[1];
    next_acc = acc;
    next_left = left;
    next_busy = busy;
    // load start phase then add step
    if (!busy && line_start && point_count != '0 && !partial_refused) begin
      // first point at the start phase
      next_acc = start_phase;
      next_left = point_count;
      next_busy = 1'b1;
    end else if (busy && cand_ready) begin
      next_acc = acc + step_eff;
      next_left = left - CNT_W'(1);
      next_busy = (left != CNT_W'(1));
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      acc <= '0;
      left <= '0;
      busy <= 1'b0;
    end else begin
      acc <= next_acc;
      left <= next_left;
      busy <= next_busy;
    end
  end

  rsp_buf2 #(.WIDTH($bits(rsp_point_t))) u_buf (
    .clock(clock),
    .rst(rst),
    .in_valid(busy),
    .in_ready(cand_ready),
    .in_data(cand),
    .out_valid(point_valid),
    .out_ready(point_ready),
    .out_data(point)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_start;
    !busy && line_start && point_count != '0 && !partial_refused;
  endsequence

  chk_start_load_phase : assert property (@(posedge clock) disable iff (rst)
    s_start |=> acc == $past(start_phase)) else $error("accumulator not loaded with start phase");
  chk_step_added : assert property (@(posedge clock) disable iff (rst)
    busy && cand_ready && left != CNT_W'(1) |=> acc == $past(acc) + $past(step_eff))
    else $error("accumulator did not advance by step");
  chk_unity_step : assert property (@(posedge clock) disable iff (rst)
    !setup[RSP_SETUP_EN] |-> step_eff == ACC_W'({RSP_UNITY_INT, RSP_UNITY_FRAC}))
    else $error("disabled resize not unity step");
  chk_weights_sum : assert property (@(posedge clock) disable iff (rst)
    busy |-> ({1'b0, cand.weight_far} + cand.weight_near) == (RSP_FRAC_W+1)'(1 << RSP_FRAC_W))
    else $error("weights do not span one pixel");
  chk_half_equal : assert property (@(posedge clock) disable iff (rst)
    busy && acc[RSP_FRAC_W-1:0] == RSP_HALF_PHASE |-> cand.weight_near == {1'b0, cand.weight_far})
    else $error("half phase not equal weights");
  chk_grad_block : assert property (@(posedge clock) disable iff (rst)
    partial_refused && !busy |=> !busy) else $error("partial run started under gradation");
  chk_hphase_write : assert property (@(posedge clock) disable iff (rst)
    wr_fire && aw_addr == RSP_OFF_HPHASE && w_strb == 4'hf
    |=> hphase == {$past(w_data[RSP_INT_LSB +: RSP_HINT_W]), $past(w_data[RSP_FRAC_W-1:0])})
    else $error("horizontal phase not stored");
  chk_vstep_write : assert property (@(posedge clock) disable iff (rst)
    wr_fire && aw_addr == RSP_OFF_VSTEP && w_strb == 4'hf
    |=> vstep == {$past(w_data[RSP_INT_LSB +: RSP_DINT_W]), $past(w_data[RSP_FRAC_W-1:0])})
    else $error("vertical step not stored");
  chk_vphase_write : assert property (@(posedge clock) disable iff (rst)
    wr_fire && aw_addr == RSP_OFF_VPHASE && w_strb == 4'hf
    |=> vphase.ipart == $past(w_data[RSP_INT_LSB +: RSP_VINT_W])) else $error("vertical phase not stored");
  chk_method_sel : assert property (@(posedge clock) disable iff (rst)
    busy && !vert_axis |-> cand.nearest == method[0] && cand.nearest_alpha == method[1])
    else $error("method selector mismatch");

endmodule : rsp_ctrl
`default_nettype wire

// [src/rsp_pkg.sv]
/*
  Package for the resize start-phase control block: register offsets, field
  layouts, reset values and the packed structs passed between files.
  Assumes a 32-bit AXI4-Lite register bus and a 125 MHz single clock.
*/
package rsp_pkg;

  // ----------------------------------------------------------------
  // Field widths
  // ----------------------------------------------------------------
  localparam int RSP_FRAC_W = 12;
  localparam int RSP_HINT_W = 10;
  localparam int RSP_VINT_W = 9;
  localparam int RSP_DINT_W = 2;
  localparam int RSP_SIZE_W = 12;
  localparam int RSP_ADDR_W = 6;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [RSP_ADDR_W-1:0] RSP_OFF_SETUP = 6'h00;
  localparam logic [RSP_ADDR_W-1:0] RSP_OFF_METHOD = 6'h04;
  localparam logic [RSP_ADDR_W-1:0] RSP_OFF_HPHASE = 6'h08;
  localparam logic [RSP_ADDR_W-1:0] RSP_OFF_VPHASE = 6'h0c;
  localparam logic [RSP_ADDR_W-1:0] RSP_OFF_HSTEP = 6'h10;
  localparam logic [RSP_ADDR_W-1:0] RSP_OFF_VSTEP = 6'h14;
  localparam logic [RSP_ADDR_W-1:0] RSP_OFF_AREA = 6'h18;
  localparam logic [RSP_ADDR_W-1:0] RSP_OFF_STATUS = 6'h1c;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int RSP_SETUP_EN = 0;
  localparam int RSP_SETUP_REDGE = 1;
  localparam int RSP_SETUP_BEDGE = 2;
  localparam int RSP_SETUP_PART = 3;
  localparam int RSP_SETUP_GRAD = 4;
  localparam int RSP_INT_LSB = 16;
  localparam int RSP_AREA_H_LSB = 16;

  // ----------------------------------------------------------------
  // Reset values and constants
  // ----------------------------------------------------------------
  localparam logic [RSP_DINT_W-1:0] RSP_UNITY_INT = 2'h1;
  localparam logic [RSP_FRAC_W-1:0] RSP_UNITY_FRAC = 12'h000;
  localparam logic [RSP_FRAC_W-1:0] RSP_HALF_PHASE = 12'h800;
  localparam logic [1:0] RSP_RESP_OKAY = 2'h0;
  localparam logic [1:0] RSP_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [RSP_HINT_W-1:0] ipart;
    logic [RSP_FRAC_W-1:0] fpart;
  } rsp_hphase_t;

  typedef struct packed {
    logic [RSP_VINT_W-1:0] ipart;
    logic [RSP_FRAC_W-1:0] fpart;
  } rsp_vphase_t;

  typedef struct packed {
    logic [RSP_DINT_W-1:0] ipart;
    logic [RSP_FRAC_W-1:0] fpart;
  } rsp_step_t;

  // Per-axis interpolation point handed to the filter datapath
  typedef struct packed {
    logic [RSP_HINT_W-1:0] src_index;
    logic [RSP_FRAC_W-1:0] weight_far;
    logic [RSP_FRAC_W:0] weight_near;
    logic nearest;
    logic nearest_alpha;
  } rsp_point_t;

endpackage : rsp_pkg

// [tb/resize_start_phase_control_tb_top.sv]
/*
  Self-checking bench for rsp_ctrl: register access over AXI4-Lite and runs of
  interpolation points. Assumes rsp_pkg is compiled first; checks sit in the design.
*/
`timescale 1ns/10ps
`default_nettype none
module resize_start_phase_control_tb_top import rsp_pkg::*;;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [RSP_ADDR_W-1:0] awaddr = '0;
  logic [RSP_ADDR_W-1:0] araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, run_busy, point_valid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic line_start = 1'b0, vert_axis = 1'b0, point_ready = 1'b0;
  logic [11:0] point_count = 12'h000;
  rsp_point_t point;
  int fail_count = 0;
  int num_checks = 0;

  rsp_ctrl #(.CNT_W(12)) rsp_ctrl_i (
    .clock(clock), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .line_start(line_start), .point_count(point_count), .vert_axis(vert_axis),
    .run_busy(run_busy), .point_valid(point_valid), .point_ready(point_ready), .point(point)
  );

  initial begin
    forever #4 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Sampling right after the edge sees the values the edge itself saw
  task automatic bus_wr(input logic [RSP_ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    logic done;
    done = 1'b0;
    // Let an edge pass so back-to-back calls never drive a strobe twice in one step
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 64 && !done; n++) begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        done = 1'b1;
        bready <= 1'b0;
        check(64'(bresp), 64'(er));
      end
    end
    check(64'(done), 64'h1);
  endtask : bus_wr

  task automatic bus_rd(input logic [RSP_ADDR_W-1:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 64 && !done; n++) begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        done = 1'b1;
        rready <= 1'b0;
        check(64'(rdata), 64'(ed));
        check(64'(rresp), 64'(er));
      end
    end
    check(64'(done), 64'h1);
  endtask : bus_rd

  // One run: point k must carry start + k*step, then the stream falls silent
  task automatic walk(input logic v, input int n, input logic [21:0] p0, input logic [21:0] st,
                      input logic [1:0] sel, input int stall);
    logic [21:0] ph;
    logic got;
    vert_axis <= v;
    point_count <= 12'(n);
    line_start <= 1'b1;
    @(posedge clock);
    line_start <= 1'b0;
    @(posedge clock);
    check(64'(run_busy), 64'h1);
    repeat (stall) @(posedge clock);
    for (int k = 0; k < n; k++) begin
      ph = p0 + 22'(k) * st;
      got = 1'b0;
      for (int w = 0; w < 64 && !got; w++) begin
        @(posedge clock);
        got = point_valid;
      end
      check(64'(point), 64'({ph[21:12], ph[11:0], 13'h1000 - {1'b0, ph[11:0]}, sel}));
      point_ready <= 1'b1;
      @(posedge clock);
      point_ready <= 1'b0;
    end
    for (int w = 0; w < 16 && run_busy; w++) @(posedge clock);
    @(posedge clock);
    check(64'({run_busy, point_valid}), 64'h0);
  endtask : walk

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    bus_rd(RSP_OFF_SETUP, 32'h0, RSP_RESP_OKAY);
    bus_rd(RSP_OFF_METHOD, 32'h0, RSP_RESP_OKAY);
    bus_rd(RSP_OFF_HPHASE, 32'h0, RSP_RESP_OKAY);
    bus_rd(RSP_OFF_VPHASE, 32'h0, RSP_RESP_OKAY);
    bus_rd(RSP_OFF_HSTEP, 32'h00010000, RSP_RESP_OKAY);
    bus_rd(RSP_OFF_VSTEP, 32'h00010000, RSP_RESP_OKAY);
    bus_rd(RSP_OFF_AREA, 32'h0, RSP_RESP_OKAY);
    bus_rd(RSP_OFF_STATUS, 32'h0, RSP_RESP_OKAY);
  endtask : t_reset

  // Field widths, byte strobes, read-only and unmapped places
  task automatic t_fields;
    bus_wr(RSP_OFF_HPHASE, 32'hffffffff, 4'hf, RSP_RESP_OKAY);
    bus_rd(RSP_OFF_HPHASE, 32'h03ff0fff, RSP_RESP_OKAY);
    bus_wr(RSP_OFF_HPHASE, 32'h0, 4'h4, RSP_RESP_OKAY);
    bus_rd(RSP_OFF_HPHASE, 32'h03000fff, RSP_RESP_OKAY);
    bus_wr(RSP_OFF_VPHASE, 32'hffffffff, 4'hf, RSP_RESP_OKAY);
    bus_rd(RSP_OFF_VPHASE, 32'h01ff0fff, RSP_RESP_OKAY);
    bus_wr(RSP_OFF_VSTEP, 32'hffffffff, 4'hf, RSP_RESP_OKAY);
    bus_rd(RSP_OFF_VSTEP, 32'h00030fff, RSP_RESP_OKAY);
    bus_wr(RSP_OFF_METHOD, 32'hffffffff, 4'hf, RSP_RESP_OKAY);
    bus_rd(RSP_OFF_METHOD, 32'h0000000f, RSP_RESP_OKAY);
    bus_wr(RSP_OFF_AREA, 32'hffffffff, 4'hf, RSP_RESP_OKAY);
    bus_rd(RSP_OFF_AREA, 32'h0fff0fff, RSP_RESP_OKAY);
    bus_wr(RSP_OFF_STATUS, 32'hffffffff, 4'hf, RSP_RESP_OKAY);
    bus_rd(RSP_OFF_STATUS, 32'h0, RSP_RESP_OKAY);
    bus_wr(6'h20, 32'h1, 4'hf, RSP_RESP_SLVERR);
    bus_rd(6'h20, 32'h0, RSP_RESP_SLVERR);
  endtask : t_fields

  // Half phase with a stalled sink, then zero phase with a 1.5 step
  task automatic t_phase;
    bus_wr(RSP_OFF_SETUP, 32'h1, 4'hf, RSP_RESP_OKAY);
    bus_wr(RSP_OFF_METHOD, 32'h0, 4'hf, RSP_RESP_OKAY);
    bus_wr(RSP_OFF_HPHASE, {20'h0, RSP_HALF_PHASE}, 4'hf, RSP_RESP_OKAY);
    bus_wr(RSP_OFF_HSTEP, 32'h00020000, 4'hf, RSP_RESP_OKAY);
    walk(1'b0, 4, 22'h000800, 22'h002000, 2'b00, 6);
    bus_wr(RSP_OFF_HPHASE, 32'h0, 4'hf, RSP_RESP_OKAY);
    bus_wr(RSP_OFF_HSTEP, 32'h00010800, 4'hf, RSP_RESP_OKAY);
    walk(1'b0, 3, 22'h000000, 22'h001800, 2'b00, 0);
  endtask : t_phase

  // Resize off must walk at unity while the step field keeps its value
  task automatic t_resize_off;
    bus_wr(RSP_OFF_SETUP, 32'h0, 4'hf, RSP_RESP_OKAY);
    bus_wr(RSP_OFF_HPHASE, 32'h00000000, 4'hf, RSP_RESP_OKAY);
    walk(1'b0, 3, 22'h000000, 22'h001000, 2'b00, 0);
    bus_rd(RSP_OFF_HSTEP, 32'h00010800, RSP_RESP_OKAY);
  endtask : t_resize_off

  // Each selector alone, on the axis it belongs to
  task automatic t_selectors;
    logic [3:0] m;
    bus_wr(RSP_OFF_SETUP, 32'h1, 4'hf, RSP_RESP_OKAY);
    bus_wr(RSP_OFF_HPHASE, 32'h00000800, 4'hf, RSP_RESP_OKAY);
    bus_wr(RSP_OFF_VPHASE, 32'h00000400, 4'hf, RSP_RESP_OKAY);
    bus_wr(RSP_OFF_VSTEP, 32'h00000800, 4'hf, RSP_RESP_OKAY);
    for (int b = 0; b < 4; b++) begin
      m = 4'h1 << b;
      bus_wr(RSP_OFF_METHOD, {28'h0, m}, 4'hf, RSP_RESP_OKAY);
      if (b > 1) walk(1'b1, 3, 22'h000400, 22'h000800, {m[2], m[3]}, 1);
      else walk(1'b0, 2, 22'h000800, 22'h001800, {m[0], m[1]}, 1);
    end
  endtask : t_selectors

  // Partial area with gradation is refused; partial alone runs
  task automatic t_partial;
    bus_wr(RSP_OFF_SETUP, 32'h19, 4'hf, RSP_RESP_OKAY);
    point_count <= 12'h002;
    line_start <= 1'b1;
    @(posedge clock);
    line_start <= 1'b0;
    repeat (3) @(posedge clock);
    check(64'({run_busy, point_valid}), 64'h0);
    bus_rd(RSP_OFF_STATUS, 32'h2, RSP_RESP_OKAY);
    bus_wr(RSP_OFF_SETUP, 32'h0f, 4'hf, RSP_RESP_OKAY);
    bus_rd(RSP_OFF_SETUP, 32'h0f, RSP_RESP_OKAY);
    // Updated area of 50 plus a margin of one on each side
    bus_wr(RSP_OFF_AREA, 32'h00340034, 4'hf, RSP_RESP_OKAY);
    bus_rd(RSP_OFF_AREA, 32'h00340034, RSP_RESP_OKAY);
    bus_wr(RSP_OFF_METHOD, 32'h0, 4'hf, RSP_RESP_OKAY);
    walk(1'b0, 1, 22'h000800, 22'h001800, 2'b00, 0);
  endtask : t_partial

  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_reset();
    t_fields();
    t_phase();
    t_resize_off();
    t_selectors();
    t_partial();
    tally_and_finish();
  end

  // Whole run needs a few hundred cycles; this cuts a hang short
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    tally_and_finish();
  end
endmodule : resize_start_phase_control_tb_top
`default_nettype wire
